// ---- core/ehp_pkg.sv ----
package ehp_pkg;
  // register indices on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_IRQ_STS = 4'h1;
  localparam logic [3:0] REG_IRQ_MASK = 4'h2;
  localparam logic [3:0] REG_IO_CFG = 4'h3;
  localparam logic [3:0] REG_MODE = 4'h4;
  localparam logic [3:0] REG_ADDR_CNT = 4'h5;
  localparam logic [3:0] REG_END_ADDR = 4'h6;
  localparam logic [3:0] REG_BUF = 4'h7;
  localparam logic [3:0] REG_BUF_STS = 4'h8;
  // control register bits
  localparam int CTRL_RXB_ENB = 0;
  localparam int CTRL_TXB_ENB = 1;
  localparam int CTRL_MC_ENB = 2;
  // interrupt status / mask bits
  localparam int IRQ_HOST_WR = 0;
  localparam int IRQ_HOST_RD = 1;
  localparam int IRQ_MC_END = 2;
  localparam int IRQ_W = 3;
  // external i/o configuration bits
  localparam int CFG_DREQ_EN = 0;
  localparam int CFG_DACK_EN = 1;
  localparam int CFG_TC_EN = 2;
  localparam int CFG_STS_EN = 3;
  localparam int CFG_INT_SEL_LO = 4;
  localparam int CFG_DREQ_SEL = 6;
  // mode register bits
  localparam int MODE_BURST = 0;
  localparam int MODE_DIR_RD = 1;
  // host pin lanes inside the synchroniser vector
  localparam int PIN_CS_N = 0;
  localparam int PIN_A0 = 1;
  localparam int PIN_RD_N = 2;
  localparam int PIN_WR_N = 3;
  localparam int PIN_DACK_N = 4;
  localparam int PIN_TC = 5;
  localparam int PIN_A1 = 6;
  localparam int PIN_W = 7;
  // host interrupt pin selections
  localparam logic [1:0] INT_SEL_TXB = 2'h0;
  localparam logic [1:0] INT_SEL_RXB = 2'h1;
  localparam logic [1:0] INT_SEL_MCH = 2'h2;
  // memory channel status codes
  localparam logic [1:0] MC_IDLE = 2'h0;
  localparam logic [1:0] MC_RUN = 2'h1;
  localparam logic [1:0] MC_END_ADDR = 2'h2;
  localparam logic [1:0] MC_END_TC = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [PIN_W-1:0] PIN_IDLE = 7'h1d; // strobes and selects inactive
endpackage

// ---- core/ehp_pin_if.sv ----
`timescale 1ns/100ps
interface ehp_pin_if #(parameter int W = 1);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ---- core/ehp_pin_sync.sv ----
`timescale 1ns/100ps
module ehp_pin_sync import ehp_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] raw_i,
  ehp_pin_if.src pin
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  ////////////////////////////////////////////////////////////////////////////
  // a change counts only once stages two and three agree
  assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  assign pin.level = lvl_q;
  assign pin.rise = lvl_d & ~lvl_q;
  assign pin.fall = ~lvl_d & lvl_q;

  // three-stage chain; stage one feeds nothing but stage two
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= IDLE;
      s2_q <= IDLE;
      s3_q <= IDLE;
      lvl_q <= IDLE;
    end else begin
      s1_q <= raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end
endmodule

// ---- core/ehp_top.sv ----
// Function
// (R1) cpu channel bytes serviced by firmware interrupt
// (R2) memory channel moves bytes to shared ram
// (R3) synced strobe rise, ram move in two clocks
// (R4) usb ram access wins, two clocks delay
// (R5) host spaces accesses to allow transfer completion
// (R6) burst bit selects fastest memory channel mode
// (R7) four controls, eight data, one interrupt
// (R8) dma and status pins enabled by software
// (R9) command decoder derives internal strobes
// (R10) cpu channel gated by external pins only
// (R11) memory channel gated by config and enables
// (R12) selector drives interrupt and dma request pins
// (R13) select high: cpu channel, raise interrupt
// (R14) select low: ram, auto-incrementing address
// (R15) request pulses per byte, or burst level
// (R16) terminal count on write: last, status 11
// (R17) usb collision stalls ram move, byte kept
`timescale 1ns/100ps
module ehp_top import ehp_pkg::*; #(
  parameter int AW = 11
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic HOST_CHIP_SELECT_N_I,
  input wire logic HOST_CHANNEL_SELECT_I,
  input wire logic HOST_READ_STROBE_N_I,
  input wire logic HOST_WRITE_STROBE_N_I,
  input wire logic [7:0] HOST_DATA_BUS_I,
  output logic [7:0] HOST_DATA_BUS_O,
  output logic HOST_DATA_BUS_OE_O,
  output logic HOST_INTERRUPT_OUT_O,
  input wire logic DMA_TERMINAL_COUNT_I,
  input wire logic DMA_ACKNOWLEDGE_N_I,
  input wire logic BUFFER_STATUS_SELECT_I,
  output logic DMA_REQUEST_OUT_O,
  input wire logic PORT_DREQ_PIN_VAL_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic IRQ_O,
  output logic RAM_REQ_O,
  output logic RAM_WE_O,
  output logic [AW-1:0] RAM_ADDR_O,
  output logic [7:0] RAM_WDATA_O,
  input wire logic [7:0] RAM_RDATA_I,
  input wire logic USB_RAM_BUSY_I
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_REQ = 4'b0010,
    S_CAP = 4'b0100,
    S_END = 4'b1000
  } ehp_state_t;

  ehp_pin_if #(.W(PIN_W)) ctl ();
  ehp_pin_if #(.W(8)) dat ();
  ehp_state_t st_q, st_d;
  logic [7:0] ctrl_q, cfg_q, mode_q, txbuf_q, rxbuf_q, wdat_q, hdata_q, rdata_q;
  logic [IRQ_W-1:0] sts_q, mask_q, sts_set;
  logic [AW-1:0] addr_q, end_q;
  logic [1:0] mcst_q;
  logic tx_empty_q, rx_full_q, mc_wr_q, last_q, req_q, ram_req_q, ram_we_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the host bus is asynchronous to the core clock
  ehp_pin_sync #(.W(PIN_W), .IDLE(PIN_IDLE)) u_ctl_sync (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .raw_i({BUFFER_STATUS_SELECT_I, DMA_TERMINAL_COUNT_I, DMA_ACKNOWLEDGE_N_I,
            HOST_WRITE_STROBE_N_I, HOST_READ_STROBE_N_I, HOST_CHANNEL_SELECT_I,
            HOST_CHIP_SELECT_N_I}),
    .pin(ctl)
  );

  ehp_pin_sync #(.W(8), .IDLE(RST_BYTE)) u_dat_sync (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .raw_i(HOST_DATA_BUS_I),
    .pin(dat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command decoder
  wire cs = ~ctl.level[PIN_CS_N];
  wire a0 = ctl.level[PIN_A0];
  wire rd_low = ~ctl.level[PIN_RD_N];
  wire wr_low = ~ctl.level[PIN_WR_N];
  wire rd_end = ctl.rise[PIN_RD_N]; // access completes on the strobe rise [R3]
  wire wr_end = ctl.rise[PIN_WR_N];
  wire dack_on = cfg_q[CFG_DACK_EN] & ~ctl.level[PIN_DACK_N]; // [R8]
  wire tc_on = cfg_q[CFG_TC_EN] & ctl.level[PIN_TC]; // [R8]
  wire cch_sel = cs & a0; // pins alone, no internal gating [R10] [R13]
  wire mch_sel = (cs & ~a0) | dack_on; // dack alone acts as ram select [R14]
  wire mc_run = ctrl_q[CTRL_MC_ENB] & (mcst_q == MC_RUN);
  wire ram_receive_enable = mc_run & ~mode_q[MODE_DIR_RD] & st_q[0];
  wire ram_transmit_enable = mc_run & mode_q[MODE_DIR_RD] & st_q[0];
  wire cch_rd = cch_sel & rd_end; // [R9]
  wire cch_wr = cch_sel & wr_end; // [R9]
  wire mch_rd = mch_sel & rd_end & ram_transmit_enable; // [R9] [R11]
  wire mch_wr = mch_sel & wr_end & ram_receive_enable; // [R9] [R11]
  wire ram_path_last_byte = mch_wr & tc_on; // [R9] [R16]
  wire buf_wr = cch_wr | mch_wr; // [R9]
  wire stt_sel = cfg_q[CFG_STS_EN] & ctl.level[PIN_A1]; // [R9] [R8]
  wire data_output_enable = (cs | dack_on) & rd_low; // [R9]
  wire [7:0] status_byte = {3'h0, mcst_q, sts_q[IRQ_MC_END], rx_full_q, tx_empty_q};

  ////////////////////////////////////////////////////////////////////////////
  // output selector for the interrupt and dma request pins
  wire tx_buffer_ready = ctrl_q[CTRL_TXB_ENB] & ~tx_empty_q;
  wire rx_buffer_ready = ctrl_q[CTRL_RXB_ENB] & ~rx_full_q;
  wire [1:0] int_sel = cfg_q[CFG_INT_SEL_LO +: 2];
  // burst holds the request over the whole address run; otherwise one pulse
  // per byte, dropped while the host strobe is low so the dma sees an edge
  wire mch_req = mode_q[MODE_BURST] ? mc_run : req_q; // [R6] [R15]
  wire int_pin = (int_sel == INT_SEL_TXB) ? tx_buffer_ready :
                 (int_sel == INT_SEL_RXB) ? rx_buffer_ready :
                 (int_sel == INT_SEL_MCH) ? mch_req : 1'b0; // [R12]
  wire dreq_fn = cfg_q[CFG_DREQ_SEL] ? mch_req : rx_buffer_ready; // [R12]

  assign HOST_INTERRUPT_OUT_O = int_pin; // [R7]
  // disabled pin keeps its ordinary port value
  assign DMA_REQUEST_OUT_O = cfg_q[CFG_DREQ_EN] ? dreq_fn : PORT_DREQ_PIN_VAL_I; // [R8]
  assign HOST_DATA_BUS_OE_O = data_output_enable; // [R7]
  assign HOST_DATA_BUS_O = hdata_q;

  // per-byte request: armed when ready, cleared while a strobe is active
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      req_q <= 1'b0;
    end else begin
      req_q <= (ram_receive_enable | ram_transmit_enable) & ~rd_low & ~wr_low; // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host data path: write data sampled while the strobe is low, since the
  // bus may already be released when the synced rise arrives
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      wdat_q <= RST_BYTE;
      hdata_q <= RST_BYTE;
    end else begin
      if (wr_low) begin
        wdat_q <= dat.level;
      end
      hdata_q <= stt_sel ? status_byte : txbuf_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared buffers and cpu channel flags; hardware set wins over cpu clear
  wire cpu_buf_wr = REG_WR_I & (REG_ADDR_I == REG_BUF);
  wire cpu_buf_rd = REG_RD_I & (REG_ADDR_I == REG_BUF);

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      rxbuf_q <= RST_BYTE;
      txbuf_q <= RST_BYTE;
      rx_full_q <= 1'b0;
      tx_empty_q <= 1'b1;
    end else begin
      if (buf_wr) begin
        rxbuf_q <= wdat_q;
      end
      if (st_q[2] & ~ram_we_q) begin
        txbuf_q <= RAM_RDATA_I; // prefetched byte for the next host read
      end else if (cpu_buf_wr) begin
        txbuf_q <= REG_WDATA_I;
      end
      rx_full_q <= cch_wr | (rx_full_q & ~cpu_buf_rd); // [R1]
      tx_empty_q <= cch_rd | (tx_empty_q & ~cpu_buf_wr); // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory channel sequencer: one request cycle, one capture cycle [R3]
  wire rd_start = ctrl_q[CTRL_MC_ENB] & mode_q[MODE_DIR_RD] & (mcst_q == MC_IDLE);
  wire wr_start = ctrl_q[CTRL_MC_ENB] & ~mode_q[MODE_DIR_RD] & (mcst_q == MC_IDLE);
  wire at_end = (addr_q == end_q);

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (mch_wr | mch_rd | rd_start) begin
          st_d = S_REQ;
        end
      end
      S_REQ: begin
        if (!USB_RAM_BUSY_I) begin // advance once usb frees the ram [R4] [R17]
          st_d = S_CAP;
        end
      end
      S_CAP: begin
        st_d = S_END;
      end
      S_END: begin
        st_d = S_IDLE;
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  wire ram_go = st_q[1] & ~USB_RAM_BUSY_I; // held request keeps the byte [R17]
  assign RAM_REQ_O = ram_req_q;
  assign RAM_WE_O = ram_we_q;
  assign RAM_ADDR_O = addr_q;
  assign RAM_WDATA_O = rxbuf_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      st_q <= S_IDLE;
      ram_req_q <= 1'b0;
      ram_we_q <= 1'b0;
      mc_wr_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ram_req_q <= ram_go; // [R2]
      ram_we_q <= ram_go & mc_wr_q;
      if (st_q[0] & (mch_wr | mch_rd | rd_start)) begin
        mc_wr_q <= mch_wr;
        last_q <= ram_path_last_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address counter and channel status; the prefetch leaves the counter on
  // the byte held for the host, and a finished host read steps it before the
  // refill, otherwise the refill would fetch the byte just handed over
  wire cpu_addr_wr = REG_WR_I & (REG_ADDR_I == REG_ADDR_CNT) & ~ctrl_q[CTRL_MC_ENB];
  wire [15:0] wdat_dup = {REG_WDATA_I, REG_WDATA_I};

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      addr_q <= '0;
      mcst_q <= MC_IDLE;
    end else begin
      if (cpu_addr_wr) begin
        addr_q <= wdat_dup[AW-1:0];
      end else if (mch_rd & ~at_end) begin
        addr_q <= addr_q + 1'b1; // read path: step before the refill [R14]
      end
      if (!ctrl_q[CTRL_MC_ENB]) begin
        mcst_q <= MC_IDLE;
      end else if (rd_start | wr_start) begin
        mcst_q <= MC_RUN;
      end else if (st_q[3] & mc_wr_q & last_q) begin
        mcst_q <= MC_END_TC; // stops before the end address if need be [R16]
      end else if (st_q[3] & mc_wr_q & at_end) begin
        mcst_q <= MC_END_ADDR;
      end else if (st_q[3] & mc_wr_q) begin
        addr_q <= addr_q + 1'b1; // write path: advance after the store [R14]
      end else if (mch_rd & at_end) begin
        mcst_q <= MC_END_ADDR; // host took the byte at the end address [R14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status, cleared by writing one; set wins [R13]
  assign sts_set[IRQ_HOST_WR] = cch_wr; // [R13]
  assign sts_set[IRQ_HOST_RD] = cch_rd; // [R13]
  assign sts_set[IRQ_MC_END] = st_q[3] & mc_wr_q & (last_q | at_end); // [R16]
  wire [IRQ_W-1:0] sts_clr = (REG_WR_I & (REG_ADDR_I == REG_IRQ_STS)) ?
                             REG_WDATA_I[IRQ_W-1:0] : '0;
  assign IRQ_O = |(sts_q & mask_q); // [R1]

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      sts_q <= '0;
    end else begin
      sts_q <= sts_set | (sts_q & ~sts_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      ctrl_q <= RST_BYTE;
      mask_q <= '0;
      cfg_q <= RST_BYTE; // all dma and status pins start as ports [R8]
      mode_q <= RST_BYTE;
      end_q <= '0;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == REG_CTRL) begin
        ctrl_q <= REG_WDATA_I;
      end else if (REG_ADDR_I == REG_IRQ_MASK) begin
        mask_q <= REG_WDATA_I[IRQ_W-1:0];
      end else if (REG_ADDR_I == REG_IO_CFG) begin
        cfg_q <= REG_WDATA_I;
      end else if (REG_ADDR_I == REG_MODE) begin
        mode_q <= REG_WDATA_I; // [R6]
      end else if (REG_ADDR_I == REG_END_ADDR) begin
        end_q <= wdat_dup[AW-1:0];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  wire [7:0] rd_mux =
    (REG_ADDR_I == REG_CTRL) ? ctrl_q :
    (REG_ADDR_I == REG_IRQ_STS) ? {5'h0, sts_q} :
    (REG_ADDR_I == REG_IRQ_MASK) ? {5'h0, mask_q} :
    (REG_ADDR_I == REG_IO_CFG) ? cfg_q :
    (REG_ADDR_I == REG_MODE) ? mode_q :
    (REG_ADDR_I == REG_ADDR_CNT) ? addr_q[7:0] :
    (REG_ADDR_I == REG_END_ADDR) ? end_q[7:0] :
    (REG_ADDR_I == REG_BUF) ? rxbuf_q :
    (REG_ADDR_I == REG_BUF_STS) ? status_byte : RST_BYTE;

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      rdata_q <= RST_BYTE;
    end else begin
      rdata_q <= REG_RD_I ? rd_mux : RST_BYTE;
    end
  end
  assign REG_RDATA_O = rdata_q;
endmodule

// ---- testbench/ehp_top_monitor.sv ----
`timescale 1ns/100ps
module ehp_top_monitor import ehp_pkg::*; #(
  parameter int AW = 11
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic HOST_READ_STROBE_N_I,
  input wire logic HOST_WRITE_STROBE_N_I,
  input wire logic HOST_DATA_BUS_OE_O,
  input wire logic DMA_REQUEST_OUT_O,
  input wire logic PORT_DREQ_PIN_VAL_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic IRQ_O,
  input wire logic RAM_REQ_O,
  input wire logic RAM_WE_O,
  input wire logic [AW-1:0] RAM_ADDR_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  ////////////////////////////////////////
  // shadows of config and mask, loaded on the same edge as the design's copies
  logic [7:0] cfg_q;
  logic [7:0] mask_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      cfg_q <= 8'h00;
      mask_q <= 8'h00;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == REG_IO_CFG) cfg_q <= REG_WDATA_I;
      if (REG_ADDR_I == REG_IRQ_MASK) mask_q <= REG_WDATA_I;
    end
  end
  ////////////////////////////////////////
  // read data stands only in the cycle after the read strobe
  rdata_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
    else $error("read data outside its cycle");
  unmapped_zero_a: assert property (REG_RD_I && REG_ADDR_I > REG_BUF_STS |=>
    REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
  req_pulse_a: assert property (RAM_REQ_O |=> !RAM_REQ_O)
    else $error("ram request longer than one cycle");
  we_with_req_a: assert property (RAM_WE_O |-> RAM_REQ_O)
    else $error("ram write without request");
  // the move may only start once the strobe has risen and passed the synchroniser
  req_after_rise_a: assert property (RAM_REQ_O |-> $past(HOST_WRITE_STROBE_N_I, 3)
    && $past(HOST_READ_STROBE_N_I, 3)) else $error("ram move before strobe rise");
  oe_idle_a: assert property (HOST_READ_STROBE_N_I [*6] |-> !HOST_DATA_BUS_OE_O)
    else $error("data bus driven without read");
  dreq_port_a: assert property (!cfg_q[CFG_DREQ_EN] |->
    DMA_REQUEST_OUT_O == PORT_DREQ_PIN_VAL_I) else $error("request pin lost port value");
  irq_mask_a: assert property (mask_q[IRQ_W-1:0] == 3'h0 |-> !IRQ_O)
    else $error("interrupt while fully masked");
  addr_step_a: assert property ($changed(RAM_ADDR_O) && !$past(REG_WR_I) |->
    RAM_ADDR_O == $past(RAM_ADDR_O) + 1'b1) else $error("address did not step by one");
  // main scenarios
  ram_wr_c: cover property (RAM_REQ_O && RAM_WE_O);
  irq_c: cover property ($rose(IRQ_O));
  dreq_c: cover property (cfg_q[CFG_DREQ_EN] && DMA_REQUEST_OUT_O);
endmodule

bind ehp_top ehp_top_monitor #(.AW(AW)) i_ehp_top_monitor (
  .CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .HOST_READ_STROBE_N_I(HOST_READ_STROBE_N_I),
  .HOST_WRITE_STROBE_N_I(HOST_WRITE_STROBE_N_I), .HOST_DATA_BUS_OE_O(HOST_DATA_BUS_OE_O),
  .DMA_REQUEST_OUT_O(DMA_REQUEST_OUT_O), .PORT_DREQ_PIN_VAL_I(PORT_DREQ_PIN_VAL_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .IRQ_O(IRQ_O), .RAM_REQ_O(RAM_REQ_O),
  .RAM_WE_O(RAM_WE_O), .RAM_ADDR_O(RAM_ADDR_O)
);

// ---- testbench/ehp_host_model.sv ----
`timescale 1ns/100ps
module ehp_host_model (
  input wire logic clk_i,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_i,
  output logic cs_n_o,
  output logic a0_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic dack_n_o,
  output logic tc_o,
  output logic a1_o,
  output logic [7:0] bus_o
);
  logic drv = 1'b0;
  logic [7:0] hd = 8'h00;
  logic [7:0] last = 8'h00;
  // no pull-ups: a free bus shows the inverse of its last level, never a stale byte
  assign bus_o = dev_oe_i ? dev_data_i : (drv ? hd : ~last);
  always @(posedge clk_i) last <= bus_o;
  // all strobes and selects idle at start
  initial begin
    cs_n_o = 1'b1;
    a0_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    dack_n_o = 1'b1;
    tc_o = 1'b0;
    a1_o = 1'b0;
  end
  // one bus cycle by chip select or dma acknowledge; read byte taken as strobe rises
  task automatic access(input logic wr, input logic ch, input logic dk, input logic t,
                        input logic s, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cs_n_o <= dk;
    dack_n_o <= !dk;
    a0_o <= ch;
    tc_o <= t;
    a1_o <= s;
    hd <= d;
    drv <= wr;
    @(posedge clk_i);
    rd_n_o <= wr;
    wr_n_o <= !wr;
    repeat (8) @(posedge clk_i);
    q = bus_o;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    dack_n_o <= 1'b1;
    drv <= 1'b0;
    tc_o <= 1'b0;
    // gap covers sync, move and the usb wait before the next access
    repeat (14) @(posedge clk_i);
  endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top import ehp_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [7:0] rwd = 8'h00;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic usb = 1'b0;
  logic usb_p = 1'b0;
  logic usb_en = 1'b0;
  logic pdreq = 1'b0;
  logic cs_n, a0, rd_n, wr_n, dack_n, tc, a1, oe, hint, dreq, irq, rreq, rwe;
  logic [7:0] bus, dout, rdat, ramrd, rwdat, q, d;
  logic [10:0] radr;
  logic [7:0] dv[9];
  logic [7:0] wq[$];
  logic [7:0] aq[$];
  int i;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 32'h2b9708d6;
  function automatic logic [7:0] ram_pat(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction
  ////////////////////////////////////////
  // clock, random port value, usb never holding the ram more than two clocks
  always #50 clk = ~clk;
  always @(posedge clk) begin
    usb <= usb_en && $random(seed) % 2 == 0 && !(usb && usb_p);
    usb_p <= usb;
    pdreq <= $random(seed) % 2 == 0;
  end
  assign ramrd = ram_pat(radr[7:0]);
  // log every ram write the block makes
  always @(posedge clk) begin
    if (rreq === 1'b1 && rwe === 1'b1) begin
      wq.push_back(rwdat);
      aq.push_back(radr[7:0]);
    end
  end
  ehp_top i_ehp_top (
    .CORE_CLK_I(clk), .SRST_I(srst), .HOST_CHIP_SELECT_N_I(cs_n),
    .HOST_CHANNEL_SELECT_I(a0), .HOST_READ_STROBE_N_I(rd_n), .HOST_WRITE_STROBE_N_I(wr_n),
    .HOST_DATA_BUS_I(bus), .HOST_DATA_BUS_O(dout), .HOST_DATA_BUS_OE_O(oe),
    .HOST_INTERRUPT_OUT_O(hint), .DMA_TERMINAL_COUNT_I(tc), .DMA_ACKNOWLEDGE_N_I(dack_n),
    .BUFFER_STATUS_SELECT_I(a1), .DMA_REQUEST_OUT_O(dreq), .PORT_DREQ_PIN_VAL_I(pdreq),
    .REG_ADDR_I(ra), .REG_WDATA_I(rwd), .REG_WR_I(rwr), .REG_RD_I(rrd), .REG_RDATA_O(rdat),
    .IRQ_O(irq), .RAM_REQ_O(rreq), .RAM_WE_O(rwe), .RAM_ADDR_O(radr), .RAM_WDATA_O(rwdat),
    .RAM_RDATA_I(ramrd), .USB_RAM_BUSY_I(usb)
  );
  ehp_host_model i_ehp_host_model (
    .clk_i(clk), .dev_data_i(dout), .dev_oe_i(oe), .cs_n_o(cs_n), .a0_o(a0), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .dack_n_o(dack_n), .tc_o(tc), .a1_o(a1), .bus_o(bus)
  );
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // strobes get a free cycle after them so no signal is set twice in a step
  task automatic rw(input logic [3:0] a, input logic [7:0] v);
    ra <= a;
    rwd <= v;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    @(posedge clk);
    q = rdat;
  endtask
  task automatic wait_irq();
    for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk);
    if (irq !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t interrupt never came", $time);
      end_of_test();
    end
  endtask
  // memory channel stopped, loaded and status cleared
  task automatic mc_setup(input logic [7:0] s, input logic [7:0] e, input logic [7:0] m,
                          input logic [7:0] c);
    rw(REG_CTRL, 8'h03);
    rw(REG_ADDR_CNT, s);
    rw(REG_END_ADDR, e);
    rw(REG_MODE, m);
    rw(REG_IO_CFG, c);
    rw(REG_IRQ_STS, 8'h07);
    wq.delete();
    aq.delete();
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(4'hf);
    chk(q, 8'h00, "unmapped");
    rw(REG_IRQ_MASK, 8'h07);
    rw(REG_CTRL, 8'h03);
    $display("test regs done");
    // host writes the cpu channel: firmware sees the byte and an interrupt
    d = 8'($random(seed));
    i_ehp_host_model.access(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, d, q);
    chk({7'h0, irq}, 8'h01, "cpu wr irq");
    rd(REG_BUF);
    chk(q, d, "rx byte");
    rw(REG_IRQ_STS, 8'h01);
    rd(REG_IRQ_STS);
    chk(q & 8'h01, 8'h00, "w1c");
    // firmware loads a byte, host pin flags it, host read takes it
    d = 8'($random(seed));
    rw(REG_BUF, d);
    chk({7'h0, hint}, 8'h01, "tx ready pin");
    i_ehp_host_model.access(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, q);
    chk(q, d, "tx byte");
    chk({7'h0, hint}, 8'h00, "tx taken");
    rd(REG_IRQ_STS);
    chk(q & 8'h02, 8'h02, "rd status");
    $display("test cpu done");
    // ram writes: refused while stopped, then nine bytes under usb contention;
    // address registers repeat the byte above bit 7, so start and end are picked to share
    // their low three bits and the run spans a multiple of eight plus one
    mc_setup(8'h20, 8'h28, 8'h00, 8'h41);
    i_ehp_host_model.access(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h99, q);
    chk(8'(wq.size()), 8'h00, "gated");
    rw(REG_CTRL, 8'h07);
    // status turns to run, then the registered request follows
    repeat (2) @(posedge clk);
    chk({7'h0, dreq}, 8'h01, "byte req");
    usb_en <= 1'b1;
    for (i = 0; i < 9; i++) begin
      dv[i] = 8'($random(seed));
      i_ehp_host_model.access(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, dv[i], q);
    end
    wait_irq();
    chk(8'(wq.size()), 8'h09, "ram writes");
    for (i = 0; i < 9; i++) begin
      chk(wq[i], dv[i], "ram data");
      chk(aq[i], 8'h20 + i[7:0], "ram addr");
    end
    rd(REG_BUF_STS);
    chk({6'h0, q[4:3]}, {6'h0, MC_END_ADDR}, "end addr");
    $display("test ram write done");
    // dma acknowledge path, terminal count stops early
    mc_setup(8'h30, 8'h37, 8'h00, 8'h0e);
    rw(REG_CTRL, 8'h07);
    for (i = 0; i < 2; i++) begin
      i_ehp_host_model.access(1'b1, 1'b0, 1'b1, i == 1, 1'b0, dv[i], q);
    end
    wait_irq();
    chk(8'(wq.size()), 8'h02, "tc writes");
    rd(REG_BUF_STS);
    chk({6'h0, q[4:3]}, {6'h0, MC_END_TC}, "tc status");
    // status byte on the host bus: end flag set, rx drained, tx empty
    i_ehp_host_model.access(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00, q);
    chk(q, {3'h0, MC_END_TC, 3'h5}, "status pin");
    $display("test tc done");
    // burst read: request held while the counter runs, then dropped
    mc_setup(8'h48, 8'h50, 8'h03, 8'h41);
    rw(REG_CTRL, 8'h07);
    repeat (6) @(posedge clk);
    chk({7'h0, dreq}, 8'h01, "burst req");
    for (i = 0; i < 9; i++) begin
      i_ehp_host_model.access(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, q);
      chk(q, ram_pat(8'h48 + i[7:0]), "ram read");
    end
    chk({7'h0, dreq}, 8'h00, "burst over");
    $display("test ram read done");
    end_of_test();
  end
endmodule
